/* File: hdl/tccr_sync.v */
// Three-stage synchroniser with edge detection for the capture input pin.
`timescale 1ns/10ps
module tccr_sync (
  input wire pclk, // System clock.
  input wire presetn, // Asynchronous reset, active low.
  input wire pin_in, // Asynchronous pin level.
  output reg level, // Filtered level, valid once two stages agree.
  output wire rise, // One-cycle pulse on a low-to-high change.
  output wire fall // One-cycle pulse on a high-to-low change.
);

  reg stage1;
  reg stage2;
  reg stage3;
  reg level_prev;

  // Stage one feeds only stage two, so no logic sees a metastable value.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
      level_prev <= 1'b0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
      level_prev <= level;
    end
  end

  assign rise = level & ~level_prev;
  assign fall = ~level & level_prev;

endmodule

/* File: hdl/tccr_top.v */
// Capture and compare registers of a free-running 16-bit timer, APB slave.
`timescale 1ns/10ps
`include "tccr_defines.vh"
module tccr_top #(
  parameter CNT_W = 16 // Width of the timer counter.
) (
  input wire pclk, // System clock, 125 MHz.
  input wire presetn, // Asynchronous reset, active low.
  input wire [`TCCR_ADDR_W-1:0] paddr, // APB byte address.
  input wire psel, // APB select.
  input wire penable, // APB access phase.
  input wire pwrite, // APB direction, high for write.
  input wire [`TCCR_DATA_W-1:0] pwdata, // APB write data.
  output reg [`TCCR_DATA_W-1:0] prdata, // APB read data.
  output wire pready, // APB ready, always high.
  output wire pslverr, // APB error for unmapped addresses.
  input wire [CNT_W-1:0] counter_value, // Running timer count.
  input wire capture_input_pin, // Capture input pin, asynchronous.
  output reg compare_output_pin, // Compare output pin.
  output wire irq // Level interrupt, high while unmasked event.
);

  localparam HALF = CNT_W / 2;

  // Register storage, deliberately outside reset.
  reg [HALF-1:0] capture_value_high;
  reg [HALF-1:0] capture_value_low;
  reg [HALF-1:0] compare_value_high;
  reg [HALF-1:0] compare_value_low;

  // Control and status state.
  reg capture_edge_select;
  reg compare_output_level;
  reg capture_event_flag;
  reg compare_match_flag;
  reg capture_clear_armed;
  reg compare_clear_armed;
  reg capture_locked;
  reg compare_suspended;
  reg match_prev;
  reg [`TCCR_IRQ_W-1:0] irq_status;
  reg [`TCCR_IRQ_W-1:0] irq_mask;

  wire pin_rise;
  wire pin_fall;
  wire capture_edge;
  wire capture_take;
  wire cap_high_busy;
  wire match_now;
  wire match_event;
  wire setup;
  wire access;
  wire wr_access;
  wire rd_access;
  wire addr_ok;
  wire [`TCCR_ADDR_W-3:0] idx;
  wire [CNT_W-1:0] compare_value;
  wire [`TCCR_BYTE_W-1:0] wbyte;
  wire rd_cap_high;
  wire rd_cap_low;
  wire rd_cmp_low;
  wire wr_cmp_high;
  wire wr_cmp_low;
  wire rd_status;
  wire rd_irq_stat;
  reg [`TCCR_BYTE_W-1:0] next_rdata;

  // Decode one printed index against the word address.
  function hit;
    input [`TCCR_ADDR_W-3:0] index;
    input [7:0] reg_index;
    begin
      hit = (index == {{(`TCCR_ADDR_W-10){1'b0}}, reg_index});
    end
  endfunction

  tccr_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(capture_input_pin),
    .level(),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // Bus phases. The slave never inserts wait states.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr_access = access & pwrite;
  assign rd_access = access & ~pwrite;
  assign idx = paddr[`TCCR_ADDR_W-1:2];
  assign wbyte = pwdata[`TCCR_BYTE_W-1:0];
  assign pready = 1'b1;

  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   (hit(idx, `TCCR_IDX_CAP_HIGH) ||
                    hit(idx, `TCCR_IDX_CAP_LOW) ||
                    hit(idx, `TCCR_IDX_CMP_HIGH) ||
                    hit(idx, `TCCR_IDX_CMP_LOW) ||
                    hit(idx, `TCCR_IDX_CTRL) ||
                    hit(idx, `TCCR_IDX_STATUS) ||
                    hit(idx, `TCCR_IDX_IRQ_STAT) ||
                    hit(idx, `TCCR_IDX_IRQ_MASK));
  assign pslverr = access & ~addr_ok;

  assign rd_cap_high = rd_access & addr_ok & hit(idx, `TCCR_IDX_CAP_HIGH);
  assign rd_cap_low = rd_access & addr_ok & hit(idx, `TCCR_IDX_CAP_LOW);
  assign rd_cmp_low = rd_access & addr_ok & hit(idx, `TCCR_IDX_CMP_LOW);
  assign wr_cmp_high = wr_access & addr_ok & hit(idx, `TCCR_IDX_CMP_HIGH);
  assign wr_cmp_low = wr_access & addr_ok & hit(idx, `TCCR_IDX_CMP_LOW);
  assign rd_status = rd_access & addr_ok & hit(idx, `TCCR_IDX_STATUS);
  assign rd_irq_stat = rd_access & addr_ok & hit(idx, `TCCR_IDX_IRQ_STAT);

  // Edge polarity picks which synchronised transition triggers a capture.
  assign capture_edge = capture_edge_select ? pin_rise : pin_fall;
  // A high byte read is in flight from its setup cycle on, so an edge then is
  // dropped rather than split the pair; the flag still records the edge.
  assign cap_high_busy = psel & ~pwrite & addr_ok &
                         hit(idx, `TCCR_IDX_CAP_HIGH);
  assign capture_take = capture_edge & ~capture_locked &
                        ~cap_high_busy;

  // Only a fresh equality counts, so a stalled counter gives one event.
  assign compare_value = {compare_value_high, compare_value_low};
  assign match_now = (counter_value == compare_value) & ~compare_suspended;
  assign match_event = match_now & ~match_prev;

  // Capture snapshot; no reset so contents survive it.
  always @(posedge pclk) begin
    if (capture_take) begin
      capture_value_high <= counter_value[CNT_W-1:HALF];
      capture_value_low <= counter_value[HALF-1:0];
    end
  end

  // Compare value; capture addresses have no write path at all.
  always @(posedge pclk) begin
    if (wr_cmp_high) begin
      compare_value_high <= wbyte[HALF-1:0];
    end
    if (wr_cmp_low) begin
      compare_value_low <= wbyte[HALF-1:0];
    end
  end

  // Control, interlocks and flags.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_edge_select <= 1'b0;
      compare_output_level <= 1'b0;
      capture_event_flag <= 1'b0;
      compare_match_flag <= 1'b0;
      capture_clear_armed <= 1'b0;
      compare_clear_armed <= 1'b0;
      capture_locked <= 1'b0;
      compare_suspended <= 1'b0;
      match_prev <= 1'b0;
      irq_mask <= `TCCR_IRQ_MASK_RESET;
    end else begin
      match_prev <= match_now;
      if (wr_access && addr_ok && hit(idx, `TCCR_IDX_CTRL)) begin
        capture_edge_select <= wbyte[`TCCR_CTRL_EDGE];
        compare_output_level <= wbyte[`TCCR_CTRL_LEVEL];
      end
      if (wr_access && addr_ok && hit(idx, `TCCR_IDX_IRQ_MASK)) begin
        irq_mask <= wbyte[`TCCR_IRQ_W-1:0];
      end

      // High byte read locks; low byte read releases.
      if (rd_cap_high) begin
        capture_locked <= 1'b1;
      end else if (rd_cap_low) begin
        capture_locked <= 1'b0;
      end

      if (wr_cmp_high) begin
        compare_suspended <= 1'b1;
      end else if (wr_cmp_low) begin
        compare_suspended <= 1'b0;
      end

      // A status read that sees a flag set arms its clear.
      if (rd_status && capture_event_flag) begin
        capture_clear_armed <= 1'b1;
      end else if (rd_cap_low) begin
        capture_clear_armed <= 1'b0;
      end
      if (rd_status && compare_match_flag) begin
        compare_clear_armed <= 1'b1;
      end else if (rd_cmp_low || wr_cmp_low) begin
        compare_clear_armed <= 1'b0;
      end

      // A new event in the clearing cycle wins over the clear.
      if (capture_edge) begin
        capture_event_flag <= 1'b1;
      end else if (rd_cap_low && capture_clear_armed) begin
        capture_event_flag <= 1'b0;
      end
      if (match_event) begin
        compare_match_flag <= 1'b1;
      end else if ((rd_cmp_low || wr_cmp_low) && compare_clear_armed) begin
        compare_match_flag <= 1'b0;
      end
    end
  end

  // Compare output pin follows the programmed level on each match.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_pin <= 1'b0;
    end else if (match_event) begin
      compare_output_pin <= compare_output_level;
    end
  end

  // Sticky interrupt events; reading them clears, but a new event wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= {`TCCR_IRQ_W{1'b0}};
    end else begin
      irq_status[`TCCR_IRQ_CAP] <= capture_edge |
        (irq_status[`TCCR_IRQ_CAP] & ~rd_irq_stat);
      irq_status[`TCCR_IRQ_CMP] <= match_event |
        (irq_status[`TCCR_IRQ_CMP] & ~rd_irq_stat);
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read data is sampled in the setup cycle so it is a flop by access.
  always @* begin
    next_rdata = {`TCCR_BYTE_W{1'b0}};
    if (hit(idx, `TCCR_IDX_CAP_HIGH)) begin
      next_rdata[HALF-1:0] = capture_value_high;
    end else if (hit(idx, `TCCR_IDX_CAP_LOW)) begin
      next_rdata[HALF-1:0] = capture_value_low;
    end else if (hit(idx, `TCCR_IDX_CMP_HIGH)) begin
      next_rdata[HALF-1:0] = compare_value_high;
    end else if (hit(idx, `TCCR_IDX_CMP_LOW)) begin
      next_rdata[HALF-1:0] = compare_value_low;
    end else if (hit(idx, `TCCR_IDX_CTRL)) begin
      next_rdata[`TCCR_CTRL_EDGE] = capture_edge_select;
      next_rdata[`TCCR_CTRL_LEVEL] = compare_output_level;
    end else if (hit(idx, `TCCR_IDX_STATUS)) begin
      next_rdata[`TCCR_ST_CAP_FLAG] = capture_event_flag;
      next_rdata[`TCCR_ST_CMP_FLAG] = compare_match_flag;
      next_rdata[`TCCR_ST_CAP_LOCK] = capture_locked;
      next_rdata[`TCCR_ST_CMP_HOLD] = compare_suspended;
    end else if (hit(idx, `TCCR_IDX_IRQ_STAT)) begin
      next_rdata[`TCCR_IRQ_W-1:0] = irq_status;
    end else if (hit(idx, `TCCR_IDX_IRQ_MASK)) begin
      next_rdata[`TCCR_IRQ_W-1:0] = irq_mask;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= {`TCCR_DATA_W{1'b0}};
    end else if (setup && !pwrite) begin
      prdata <= {{(`TCCR_DATA_W-`TCCR_BYTE_W){1'b0}}, next_rdata};
    end
  end

endmodule

/* File: include/tccr_defines.vh */
// Constants for the timer capture and compare register block.
// Notes on behaviour
// - Selected capture edge copies the 16-bit counter into capture high and low.
// - Reading capture high blocks new captures until capture low is read.
// - Capture low read clears capture flag if a flagged status read preceded.
// - Writes to either capture register change no register and no flag.
// - Counter equal to compare value performs the programmed compare pin action.
// - Writing compare high suspends matching until compare low is written.
// - Compare low read or write clears match flag after a flagged status read.
// - Edge select 1 captures rising edges, 0 captures falling edges.
// - The capture flag sets on every selected edge at the capture input.
// - The match flag sets when the counter newly equals the compare value and matching is not suspended.
// - On a match the compare pin takes the compare output level.
`ifndef TCCR_DEFINES_VH
`define TCCR_DEFINES_VH

// Printed register indices; the byte address is four times the index.
`define TCCR_IDX_CAP_HIGH 8'h14
`define TCCR_IDX_CAP_LOW 8'h15
`define TCCR_IDX_CMP_HIGH 8'h16
`define TCCR_IDX_CMP_LOW 8'h17
`define TCCR_IDX_CTRL 8'h20
`define TCCR_IDX_STATUS 8'h21
`define TCCR_IDX_IRQ_STAT 8'h22
`define TCCR_IDX_IRQ_MASK 8'h23

`define TCCR_ADDR_W 12
`define TCCR_DATA_W 32
`define TCCR_BYTE_W 8

// Control register fields.
`define TCCR_CTRL_EDGE 0
`define TCCR_CTRL_LEVEL 1
`define TCCR_CTRL_RESET 2'h0

// Status register fields.
`define TCCR_ST_CAP_FLAG 7
`define TCCR_ST_CMP_FLAG 6
`define TCCR_ST_CAP_LOCK 1
`define TCCR_ST_CMP_HOLD 0

// Interrupt status and mask fields.
`define TCCR_IRQ_CAP 0
`define TCCR_IRQ_CMP 1
`define TCCR_IRQ_W 2
`define TCCR_IRQ_MASK_RESET 2'h0

`endif

/* File: sim/tccr_cpu.sv */
// Register bus master standing in for the CPU core.
`timescale 1ns/10ps
`include "tccr_defines.vh"
module tccr_cpu (
  input wire pclk, // Clock.
  input wire [`TCCR_DATA_W-1:0] prdata, // Read data.
  input wire pready, // Ready.
  input wire pslverr, // Error.
  output reg [`TCCR_ADDR_W-1:0] paddr = 12'h000, // Address.
  output reg psel = 1'b0, // Select.
  output reg penable = 1'b0, // Access phase.
  output reg pwrite = 1'b0, // Direction.
  output reg [`TCCR_DATA_W-1:0] pwdata = 32'h0, // Write data.
  output reg hung = 1'b0 // A transfer never completed.
);
  integer n;
  // Address and data are inverted on release so stale values never pass.
  task xfer(input [11:0] a, input w, input [7:0] d,
    output [31:0] rd, output err);
    begin
      @(posedge pclk);
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 64) begin
        n = n + 1;
        @(posedge pclk);
      end
      hung = n >= 64;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~{24'h0, d};
      #1;
    end
  endtask
endmodule

/* File: sim/tccr_sva.sv */
// Port-level assertions for the capture and compare register block.
`timescale 1ns/10ps
`include "tccr_defines.vh"
module tccr_sva #(
  parameter CNT_W = 16 // Counter width.
) (
  input wire pclk, // Clock.
  input wire presetn, // Reset, active low.
  input wire [`TCCR_ADDR_W-1:0] paddr, // Address.
  input wire psel, // Select.
  input wire penable, // Access phase.
  input wire pwrite, // Direction.
  input wire [`TCCR_DATA_W-1:0] pwdata, // Write data.
  input wire [`TCCR_DATA_W-1:0] prdata, // Read data.
  input wire pready, // Ready.
  input wire pslverr, // Error.
  input wire [CNT_W-1:0] counter_value, // Count.
  input wire compare_output_pin, // Compare pin.
  input wire irq // Interrupt.
);
  wire [7:0] idx = paddr[9:2];
  wire mapped = paddr[1:0] == 2'h0 &&
    (paddr[11:4] == 8'h05 || paddr[11:4] == 8'h08);
  // Unmapped writes are refused, so the shadows ignore them too.
  wire wr = psel && penable && pwrite && mapped;
  reg [CNT_W-1:0] cmp;
  reg susp;
  reg lvl;
  reg [1:0] mask;
  // Shadow of the compare value is not reset, like the register it mirrors.
  always @(posedge pclk) begin
    if (wr && idx == `TCCR_IDX_CMP_HIGH)
      cmp[CNT_W-1:8] <= pwdata[CNT_W-9:0];
    if (wr && idx == `TCCR_IDX_CMP_LOW)
      cmp[7:0] <= pwdata[7:0];
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      susp <= 1'b0;
      lvl <= 1'b0;
      mask <= 2'h0;
    end else if (wr) begin
      if (idx == `TCCR_IDX_CMP_HIGH) susp <= 1'b1;
      if (idx == `TCCR_IDX_CMP_LOW) susp <= 1'b0;
      if (idx == `TCCR_IDX_CTRL) lvl <= pwdata[`TCCR_CTRL_LEVEL];
      if (idx == `TCCR_IDX_IRQ_MASK) mask <= pwdata[1:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("wait state");
  property p_err; psel && penable && !mapped |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_hi; prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_masked; mask == 2'h0 |-> !irq; endproperty
  a_masked: assert property (p_masked) else $error("masked irq");
  property p_cmp;
    $changed(compare_output_pin) |-> $past(counter_value) == $past(cmp);
  endproperty
  a_cmp: assert property (p_cmp) else $error("pin moved off match");
  property p_susp; $changed(compare_output_pin) |-> !$past(susp); endproperty
  a_susp: assert property (p_susp) else $error("match while held");
  property p_lvl;
    $changed(compare_output_pin) |-> compare_output_pin == $past(lvl);
  endproperty
  a_lvl: assert property (p_lvl) else $error("wrong pin level");
  property p_once;
    $changed(compare_output_pin) |=> $stable(compare_output_pin) [*2];
  endproperty
  a_once: assert property (p_once) else $error("pin toggles");
endmodule

/* File: sim/tccr_top_test.sv */
// Self-checking bench for the capture and compare register block.
`timescale 1ns/10ps
`include "tccr_defines.vh"
module tccr_top_test;
  localparam [11:0] caph = `TCCR_IDX_CAP_HIGH * 4;
  localparam [11:0] capl = `TCCR_IDX_CAP_LOW * 4;
  localparam [11:0] cmph = `TCCR_IDX_CMP_HIGH * 4;
  localparam [11:0] cmpl = `TCCR_IDX_CMP_LOW * 4;
  localparam [11:0] ctrl = `TCCR_IDX_CTRL * 4;
  localparam [11:0] stat = `TCCR_IDX_STATUS * 4;
  localparam [11:0] irqs = `TCCR_IDX_IRQ_STAT * 4;
  localparam [11:0] imsk = `TCCR_IDX_IRQ_MASK * 4;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg pin = 1'b0;
  reg run = 1'b1;
  reg [15:0] cnt = 16'h0000;
  reg [15:0] cval = 16'h0000;
  reg [15:0] cv;
  reg [31:0] rdv;
  reg err;
  integer n_errors = 0;
  integer checked = 0;
  integer i;
  integer n;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  wire psel, penable, pwrite, pready, pslverr, compare_output_pin, irq, hung;
  always #4 pclk = ~pclk;
  always @(posedge pclk) cnt <= run ? cnt + 16'h0001 : cval;
  tccr_cpu cpu (.pclk(pclk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .hung(hung));
  tccr_top #(.CNT_W(16)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .counter_value(cnt), .capture_input_pin(pin),
    .compare_output_pin(compare_output_pin), .irq(irq));
  task complete_run;
    begin
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("FAIL %0t got %h want %h", $time, seen, exp);
      end
    end
  endtask
  task acc(input [11:0] a, input w, input [7:0] d);
    begin
      cpu.xfer(a, w, d, rdv, err);
      if (hung) begin
        n_errors = n_errors + 1;
        complete_run;
      end
    end
  endtask
  task rdc(input [11:0] a, input [7:0] e);
    begin
      acc(a, 1'b0, 8'h00);
      chk(rdv, {24'h0, e});
    end
  endtask
  // Capture latency is a few cycles; ten leaves margin for the filter.
  task pin_to(input v);
    begin
      @(posedge pclk);
      pin <= v;
      repeat (10) @(posedge pclk);
      #1;
    end
  endtask
  task setc(input [15:0] v);
    begin
      @(posedge pclk);
      run <= 1'b0;
      cval <= v;
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    acc(imsk, 1'b1, 8'h02);
    for (i = 0; i < 2; i = i + 1) begin
      acc(ctrl, 1'b1, {6'h0, i == 0, 1'b1});
      cv = cnt + 16'h0040;
      acc(cmph, 1'b1, cv[15:8]);
      rdc(stat, i == 0 ? 8'h01 : 8'h41);
      acc(cmpl, 1'b1, cv[7:0]);
      rdc(stat, 8'h00);
      n = 0;
      while (compare_output_pin !== (i == 0) && n < 200) begin
        n = n + 1;
        @(posedge pclk);
      end
      chk(n < 200, 32'h1);
      if (n >= 200)
        complete_run;
      chk(irq, 32'h1);
      rdc(stat, 8'h40);
      rdc(irqs, 8'h02);
      chk(irq, 32'h0);
    end
    rdc(cmpl, cv[7:0]);
    rdc(stat, 8'h00);
    setc(16'hABCD);
    pin_to(1'b1);
    chk(irq, 32'h0);
    rdc(stat, 8'h80);
    rdc(caph, 8'hAB);
    acc(caph, 1'b1, 8'hFF);
    rdc(capl, 8'hCD);
    rdc(stat, 8'h00);
    rdc(caph, 8'hAB);
    setc(16'h5678);
    pin_to(1'b0);
    pin_to(1'b1);
    rdc(stat, 8'h82);
    rdc(capl, 8'hCD);
    setc(16'h9ABC);
    pin_to(1'b0);
    rdc(caph, 8'hAB);
    rdc(capl, 8'hCD);
    pin_to(1'b1);
    rdc(caph, 8'h9A);
    rdc(capl, 8'hBC);
    acc(ctrl, 1'b1, 8'h00);
    setc(16'h2468);
    pin_to(1'b0);
    rdc(caph, 8'h24);
    rdc(capl, 8'h68);
    acc(imsk, 1'b1, 8'h01);
    chk(irq, 32'h1);
    rdc(irqs, 8'h01);
    chk(irq, 32'h0);
    acc(12'h004, 1'b0, 8'h00);
    chk(err, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdc(caph, 8'h24);
    rdc(cmpl, cv[7:0]);
    complete_run;
  end
endmodule
bind tccr_top tccr_sva #(.CNT_W(CNT_W)) u_sva (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .counter_value(counter_value),
  .compare_output_pin(compare_output_pin), .irq(irq));
